//--- bench/rx_descriptor_queue_dma_tb_top.sv
// Testbench of the receive DMA engine: register tasks, packets, memory checks.
// Assumes the memory model and the bound port checker.
`include "rxdma_defines.svh"

module rx_descriptor_queue_dma_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import rxdma_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    reg_req_t    reg_i = '0;
    beat_t       beat_i = '0;
    mem_req_t    mem_o;
    logic        mem_ack_i;
    logic [31:0] mem_rdata_i;
    logic [31:0] rdata_o;
    logic [7:0]  rx_int_o;
    logic        beat_ready_o;
    logic [1:0]  delay = 2'b00;
    int          errors = 0;
    int          num_checks = 0;

    rx_descriptor_queue_dma dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_i(reg_i),
        .rdata_o(rdata_o), .beat_i(beat_i), .beat_ready_o(beat_ready_o), .mem_o(mem_o),
        .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .rx_int_o(rx_int_o));
    rx_mem_model mem_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_i(mem_o), .delay_i(delay),
        .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

    // Clock at 250 MHz.
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic conclude();
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_i <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        reg_i <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_i <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk_i);
        reg_i <= '0;
        #1;
        d = rdata_o;
    endtask

    task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(name, exp, d);
    endtask

    // Descriptor laid out by the host: link, buffer, size, port-owns only.
    task automatic put(input int a, input logic [31:0] nx, input logic [31:0] bf, input int sz);
        mem_u.mem[a/4]     = nx;
        mem_u.mem[a/4 + 1] = bf;
        mem_u.mem[a/4 + 2] = 32'(sz);
        mem_u.mem[a/4 + 3] = 32'h2000_0000;
    endtask

    // Sends one packet, each beat held until ready, then waits for idle.
    task automatic send(input logic [2:0] ch, input int n, input logic [7:0] b0);
        int w;
        logic [31:0] s;
        @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            beat_i <= '{1'b1, i == 0, i == n - 1, ch, b0 + 8'(i)};
            w = 0;
            @(negedge clk_i);
            while (beat_ready_o !== 1'b1) begin
                w++;
                if (w > 200) begin
                    errors++;
                    conclude();
                end
                @(negedge clk_i);
            end
            @(posedge clk_i);
        end
        beat_i <= '0;
        w = 0;
        s = 32'hf;
        while (s[3:0] !== 4'h0) begin
            w++;
            if (w > 100) begin
                errors++;
                conclude();
            end
            rd(`REG_STAT, s);
        end
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rc("head0", `REG_HEAD, 32'h0);
        rc("ctrl", `REG_CTRL, 32'h0);
        rc("mask", `REG_MASK, 32'h0);
        rc("pend", `REG_PEND, 32'h0);
        rc("unmapped", 8'h90, 32'h0);
        for (int c = 0; c < 8; c++) wr(`REG_HEAD + 8'(4*c), 32'h0);
        put(32'h100, 32'h110, 32'h200, 4);
        put(32'h110, 32'h0, 32'h300, 4);
        wr(`REG_SKIP + 8'h04, 32'h2);
        wr(`REG_MASK, 32'hff);
        wr(`REG_CTRL, 32'h1);
        wr(`REG_HEAD + 8'h04, 32'h100);
        send(3'd1, 5, 8'ha0);
        chk("buf0", 32'ha1a0, mem_u.mem[8'h80][31:16]);
        chk("buf1", 32'ha4a3a2, mem_u.mem[8'hc0][23:0]);
        chk("first_len", 32'h0002_0002, mem_u.mem[8'h42]);
        chk("first_flg", 32'h8000_0005, mem_u.mem[8'h43]);
        chk("own_clr", 32'h0, 32'(mem_u.mem[8'h43][`FLG_OWN]));
        chk("last_len", 32'h3, mem_u.mem[8'h46]);
        chk("last_flg", 32'h5, 32'(mem_u.mem[8'h47][31:28]));
        rc("comp1", `REG_COMP + 8'h04, 32'h110);
        rc("head1", `REG_HEAD + 8'h04, 32'h0);
        chk("int1", 32'h2, 32'(rx_int_o));
        wr(`REG_COMP + 8'h04, 32'h100);
        repeat (3) @(posedge clk_i);
        chk("int_kept", 32'h2, 32'(rx_int_o));
        wr(`REG_COMP + 8'h04, 32'h110);
        repeat (3) @(posedge clk_i);
        chk("int_clr", 32'h0, 32'(rx_int_o));
        rc("comp1_kept", `REG_COMP + 8'h04, 32'h110);
        send(3'd1, 1, 8'h11);
        rc("sop_ovr", `REG_OVR, 32'h2);
        wr(`REG_OVR, 32'h2);
        rc("ovr_clr", `REG_OVR, 32'h0);
        delay <= 2'b11;
        put(32'h120, 32'h130, 32'h380, 4);
        put(32'h130, 32'h0, 32'h390, 4);
        wr(`REG_HEAD, 32'h120);
        send(3'd0, 1, 8'h5c);
        chk("c0_flg", 32'hc000_0001, mem_u.mem[8'h4b]);
        chk("c0_len", 32'h1, mem_u.mem[8'h4a]);
        rc("head0_next", `REG_HEAD, 32'h130);
        rc("comp0", `REG_COMP, 32'h120);
        chk("d3_own", 32'h2000_0000, mem_u.mem[8'h4f]);
        send(3'd0, 2, 8'h66);
        chk("buf3", 32'h6766, 32'(mem_u.mem[8'he4][15:0]));
        chk("d3_flg", 32'hd000_0002, mem_u.mem[8'h4f]);
        rc("comp0b", `REG_COMP, 32'h130);
        chk("q_empty", 32'h0, mem_u.mem[8'h4c]);
        // Host links a buffer after the queue ended, then restarts the channel.
        put(32'h150, 32'h0, 32'h3b0, 4);
        mem_u.mem[8'h4c] = 32'h150;
        rc("head0_ended", `REG_HEAD, 32'h0);
        chk("misq", 32'h150, mem_u.mem[8'h4c] & {32{mem_u.mem[8'h4f][`FLG_QEND]}});
        wr(`REG_HEAD, 32'h150);
        send(3'd0, 1, 8'h88);
        rc("comp0c", `REG_COMP, 32'h150);
        chk("buf5", 32'h88, 32'(mem_u.mem[8'hec][7:0]));
        put(32'h140, 32'h0, 32'h3a0, 2);
        wr(`REG_HEAD + 8'h08, 32'h140);
        send(3'd2, 3, 8'h70);
        rc("mop_ovr", `REG_OVR, 32'h400);
        chk("d4_owned", 32'h2000_0000, mem_u.mem[8'h53]);
        rc("pend_end", `REG_PEND, 32'h1);
        wr(`REG_MASK, 32'hfe);
        @(negedge clk_i);
        chk("int_masked", 32'h0, 32'(rx_int_o));
        conclude();
    end
endmodule // rx_descriptor_queue_dma_tb_top

//--- bench/rx_dma_properties.sv
// Port checker for the receive DMA engine.
// Assumes it is bound to the engine top module; one clock, reset active low.
`include "rxdma_defines.svh"

module rx_dma_props (
    input  wire logic           clk_i,
    input  wire logic           rst_n_i,
    input  rxdma_pkg::reg_req_t reg_i,
    input  wire logic [31:0]    rdata_o,
    input  rxdma_pkg::beat_t    beat_i,
    input  wire logic           beat_ready_o,
    input  rxdma_pkg::mem_req_t mem_o,
    input  wire logic           mem_ack_i,
    input  wire logic [31:0]    mem_rdata_i,
    input  wire logic [7:0]     rx_int_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import rxdma_pkg::*;
    logic [3:0] since_wr_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Counts cycles since the last acknowledged memory write, saturating.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_wr_q <= 4'hf;
        end else if (mem_ack_i && mem_o.we) begin
            since_wr_q <= 4'h0;
        end else if (since_wr_q != 4'hf) begin
            since_wr_q <= since_wr_q + 4'h1;
        end
    end
    property p_rdata_zero;
        !$past(reg_i.rd) |-> rdata_o == 32'h0;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside slot");
    property p_int_hold;
        !$past(reg_i.wr) && !$past(reg_i.wr, 2) |-> (rx_int_o & $past(rx_int_o)) == $past(rx_int_o);
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt fell without write");
    property p_int_rise;
        ((rx_int_o & ~$past(rx_int_o)) != 8'h00) && !$past(reg_i.wr) && !$past(reg_i.wr, 2)
            |-> since_wr_q <= 4'h4;
    endproperty
    a_int_rise: assert property (p_int_rise) else $error("interrupt rose without write-back");
    property p_req_hold;
        mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we)
            && $stable(mem_o.wdata) && $stable(mem_o.be);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("memory request changed early");
    property p_byte_lane;
        mem_o.req && mem_o.we && mem_o.be != 4'hf
            |-> $onehot(mem_o.be) && mem_o.wdata == {4{mem_o.wdata[7:0]}};
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("data byte lane malformed");
    property p_desc_word;
        mem_o.req && !mem_o.we |-> mem_o.be == 4'hf && mem_o.addr[1:0] == 2'b00;
    endproperty
    a_desc_word: assert property (p_desc_word) else $error("descriptor read not a word");
    property p_ready_mem;
        mem_o.req |-> !beat_ready_o;
    endproperty
    a_ready_mem: assert property (p_ready_mem) else $error("beat ready during memory access");
    property p_pend_int;
        $past(reg_i.rd) && $past(reg_i.addr) == `REG_PEND && !$past(reg_i.wr, 2)
            && !$past(reg_i.wr, 3) |-> (rx_int_o & ~rdata_o[7:0]) == 8'h00;
    endproperty
    a_pend_int: assert property (p_pend_int) else $error("interrupt without pending");
endmodule // rx_dma_props

bind rx_descriptor_queue_dma rx_dma_props chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_i(reg_i), .rdata_o(rdata_o), .beat_i(beat_i),
    .beat_ready_o(beat_ready_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .rx_int_o(rx_int_o)
);

//--- bench/rx_mem_model.sv
// Host memory model holding descriptors and buffers, 256 words.
// Assumes requests are held until its one-cycle acknowledge.
module rx_mem_model (
    input  wire logic           clk_i,
    input  wire logic           rst_n_i,
    input  rxdma_pkg::mem_req_t mem_i,
    input  wire logic [1:0]     delay_i,
    output logic                ack_o,
    output logic [31:0]         rdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import rxdma_pkg::*;
    logic [31:0] mem [0:255];
    logic [31:0] rd_q;
    logic [1:0]  cnt_q;
    // Read data stand only with the acknowledge; otherwise the lines flip.
    assign rdata_o = ack_o ? rd_q : ~rd_q;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
            cnt_q <= 2'b00;
            rd_q  <= 32'h0;
        end else if (ack_o) begin
            ack_o <= 1'b0;
            cnt_q <= 2'b00;
        end else if (mem_i.req && cnt_q != delay_i) begin
            cnt_q <= cnt_q + 2'b01;
        end else if (mem_i.req) begin
            ack_o <= 1'b1;
            rd_q  <= mem[mem_i.addr[9:2]];
            for (int b = 0; b < 4; b++) begin
                if (mem_i.we && mem_i.be[b]) begin
                    mem[mem_i.addr[9:2]][8*b +: 8] <= mem_i.wdata[8*b +: 8];
                end
            end
        end
    end
endmodule // rx_mem_model

//--- rtl/rx_chan_table.sv
// Per-channel state of the receive DMA: head, completion, skip, pending.
// Assumes host writes arrive on the register port of the engine.
`include "rxdma_defines.svh"

module rx_chan_table (
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  rxdma_pkg::reg_req_t      host_i,
    input  rxdma_pkg::eng_upd_t      upd_i,
    output rxdma_pkg::ptr_vec_t      head_o,
    output rxdma_pkg::ptr_vec_t      comp_o,
    output rxdma_pkg::len_vec_t      skip_o,
    output logic [7:0]               pend_o
);
    import rxdma_pkg::*;

    ptr_vec_t   head_q;
    ptr_vec_t   comp_q;
    len_vec_t   skip_q;
    logic [7:0] pend_q;

    // Host write decode by register bank and channel.
    wire ch_t  hch     = host_i.addr[4:2];
    wire [7:0] bank    = host_i.addr & `REG_BANK;
    wire       head_wr = host_i.wr && (bank == `REG_HEAD);
    wire       comp_wr = host_i.wr && (bank == `REG_COMP);
    wire       skip_wr = host_i.wr && (bank == `REG_SKIP);

    // Each channel is kept independently.
    // separate channel state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            head_q <= '0;
            comp_q <= '0;
            skip_q <= '0;
            pend_q <= '0;
        end else begin
            for (int c = 0; c < `NUM_CH; c++) begin
                if (head_wr && hch == 3'(c)) begin
                    head_q[c] <= host_i.wdata;
                end else if (upd_i.head_we && upd_i.ch == 3'(c)) begin
                    head_q[c] <= upd_i.head;
                end
                if (upd_i.done && upd_i.ch == 3'(c)) begin
                    comp_q[c] <= upd_i.comp;
                    pend_q[c] <= 1'b1;
                end else if (comp_wr && hch == 3'(c) && host_i.wdata == comp_q[c]) begin
                    pend_q[c] <= 1'b0;
                end
                if (skip_wr && hch == 3'(c)) begin
                    skip_q[c] <= host_i.wdata[15:0];
                end
            end
        end
    end

    assign head_o = head_q;
    assign comp_o = comp_q;
    assign skip_o = skip_q;
    assign pend_o = pend_q;

endmodule // rx_chan_table

//--- rtl/rx_descriptor_queue_dma.sv
// Receive DMA engine: stores packet bytes into linked descriptor queues.
// Assumes a memory port that ends each request with a one-cycle ack.
//
// The address-and-strobe port and the address map are this design's own decisions.
`include "rxdma_defines.svh"

module rx_descriptor_queue_dma (
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  rxdma_pkg::reg_req_t      reg_i,
    output logic [31:0]              rdata_o,
    input  rxdma_pkg::beat_t         beat_i,
    output logic                     beat_ready_o,
    output rxdma_pkg::mem_req_t      mem_o,
    input  wire logic                mem_ack_i,
    input  wire logic [31:0]         mem_rdata_i,
    output logic [7:0]               rx_int_o
);
    import rxdma_pkg::*;

    // Returns the skip that applies to the current buffer.
    function automatic len_t skip_used(logic first, len_t skip);
        return first ? skip : 16'h0000;
    endfunction

    // Builds a memory request.
    function automatic mem_req_t mreq(logic we, ptr_t a, logic [3:0] be,
                                      logic [31:0] d);
        mem_req_t m;
        m.req   = 1'b1;
        m.we    = we;
        m.be    = be;
        m.addr  = a;
        m.wdata = d;
        return m;
    endfunction

    state_t     st_q;
    state_t     st_d;
    mem_req_t   mem_q;
    mem_req_t   mem_d;
    ptr_t       cur_q;
    ptr_t       cur_d;
    ptr_t       first_q;
    ptr_t       first_d;
    ptr_t       next_q;
    ptr_t       next_d;
    ptr_t       buf_q;
    ptr_t       buf_d;
    len_t       size_q;
    len_t       size_d;
    len_t       pos_q;
    len_t       pos_d;
    len_t       fcnt_q;
    len_t       fcnt_d;
    len_t       plen_q;
    len_t       plen_d;
    len_t       skip_q;
    len_t       skip_d;
    ch_t        ch_q;
    ch_t        ch_d;
    logic [7:0] byte_q;
    logic [7:0] byte_d;
    logic       last_q;
    logic       last_d;
    logic       isf_q;
    logic       isf_d;

    logic       en_q;
    logic [7:0] mask_q;
    logic [7:0] sop_ovr_q;
    logic [7:0] mop_ovr_q;
    logic [7:0] sop_set;
    logic [7:0] mop_set;
    logic [31:0] rdata_q;
    logic       ready;
    eng_upd_t   upd;

    ptr_vec_t   head_v;
    ptr_vec_t   comp_v;
    len_vec_t   skip_v;
    logic [7:0] pend_v;

    rx_chan_table u_table (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .host_i  (reg_i),
        .upd_i   (upd),
        .head_o  (head_v),
        .comp_o  (comp_v),
        .skip_o  (skip_v),
        .pend_o  (pend_v)
    );

    // Memory handshake and buffer bookkeeping.
    wire        acc      = mem_q.req && mem_ack_i;
    wire len_t  pos_nx   = pos_q + 16'h0001;
    wire len_t  cnt_now  = pos_nx - skip_used(isf_q, skip_q);
    wire        full     = pos_nx >= size_q;
    wire        single   = cur_q == first_q;
    wire        q_end    = next_q == `RST_PTR;
    wire ptr_t  byte_adr = buf_q + {16'h0000, pos_q};
    wire [3:0]  byte_be  = 4'h1 << byte_adr[1:0];
    wire ptr_t  sop_head = head_v[beat_i.ch];
    wire        no_queue = sop_head == `RST_PTR;

    // Flag word of the final descriptor when it differs from the first.
    wire [31:0] lflags   = (32'h1 << `FLG_LAST) | (q_end ? (32'h1 << `FLG_QEND) : 32'h0);

    // Flag word of the first descriptor; port-owns left clear.
    wire [31:0] fflags   = (32'h1 << `FLG_FIRST) | {16'h0000, plen_q}
                         | (single ? lflags : 32'h0);

    // Packet state machine.
    always_comb begin
        st_d    = st_q;
        mem_d   = mem_q;
        cur_d   = cur_q;
        first_d = first_q;
        next_d  = next_q;
        buf_d   = buf_q;
        size_d  = size_q;
        pos_d   = pos_q;
        fcnt_d  = fcnt_q;
        plen_d  = plen_q;
        skip_d  = skip_q;
        ch_d    = ch_q;
        byte_d  = byte_q;
        last_d  = last_q;
        isf_d   = isf_q;
        sop_set = 8'h00;
        mop_set = 8'h00;
        ready   = 1'b0;
        upd     = '0;
        if (acc) begin
            mem_d.req = 1'b0;
        end
        unique case (st_q)
            ST_IDLE: begin
                if (beat_i.valid && !beat_i.first) begin
                    ready = 1'b1;
                end else if (beat_i.valid && (!en_q || no_queue)) begin
                    ready = 1'b1;
                    sop_set[beat_i.ch] = en_q;
                    st_d = beat_i.last ? ST_IDLE : ST_DROP;
                end else if (beat_i.valid) begin
                    ch_d    = beat_i.ch;
                    cur_d   = sop_head;
                    first_d = sop_head;
                    isf_d   = 1'b1;
                    plen_d  = 16'h0000;
                    skip_d  = skip_v[beat_i.ch];
                    mem_d   = mreq(1'b0, sop_head + `DESC_NEXT, 4'hf, 32'h0);
                    st_d    = ST_RD_NEXT;
                end
            end
            ST_RD_NEXT: begin
                if (acc) begin
                    next_d = mem_rdata_i;
                    mem_d  = mreq(1'b0, cur_q + `DESC_BUF, 4'hf, 32'h0);
                    st_d   = ST_RD_BUF;
                end
            end
            ST_RD_BUF: begin
                if (acc) begin
                    buf_d = mem_rdata_i;
                    mem_d = mreq(1'b0, cur_q + `DESC_LEN, 4'hf, 32'h0);
                    st_d  = ST_RD_LEN;
                end
            end
            ST_RD_LEN: begin
                if (acc) begin
                    size_d = mem_rdata_i[15:0];
                    pos_d  = skip_used(isf_q, skip_q);
                    st_d   = ST_DATA;
                end
            end
            ST_DATA: begin
                ready = 1'b1;
                if (beat_i.valid) begin
                    byte_d = beat_i.data;
                    last_d = beat_i.last;
                    mem_d  = mreq(1'b1, byte_adr, byte_be, {4{beat_i.data}});
                    st_d   = ST_DATA_WR;
                end
            end
            ST_DATA_WR: begin
                if (acc) begin
                    pos_d  = pos_nx;
                    plen_d = plen_q + 16'h0001;
                    if (isf_q && (last_q || full)) begin
                        fcnt_d = cnt_now;
                    end
                    if (last_q && single) begin
                        mem_d = mreq(1'b1, first_q + `DESC_LEN, 4'hf, {skip_q, cnt_now});
                        st_d  = ST_W_FLEN;
                    end else if (last_q) begin
                        mem_d = mreq(1'b1, cur_q + `DESC_LEN, 4'hf, {16'h0000, cnt_now});
                        st_d  = ST_W_LLEN;
                    end else if (full && q_end) begin
                        mop_set[ch_q] = 1'b1;
                        upd.head_we   = 1'b1;
                        upd.ch        = ch_q;
                        upd.head      = `RST_PTR;
                        st_d          = ST_DROP;
                    end else if (full) begin
                        cur_d = next_q;
                        isf_d = 1'b0;
                        mem_d = mreq(1'b0, next_q + `DESC_NEXT, 4'hf, 32'h0);
                        st_d  = ST_RD_NEXT;
                    end else begin
                        st_d = ST_DATA;
                    end
                end
            end
            ST_W_LLEN: begin
                if (acc) begin
                    mem_d = mreq(1'b1, cur_q + `DESC_FLAGS, 4'hf, lflags);
                    st_d  = ST_W_LFLG;
                end
            end
            ST_W_LFLG: begin
                if (acc) begin
                    mem_d = mreq(1'b1, first_q + `DESC_LEN, 4'hf, {skip_q, fcnt_q});
                    st_d  = ST_W_FLEN;
                end
            end
            ST_W_FLEN: begin
                if (acc) begin
                    mem_d = mreq(1'b1, first_q + `DESC_FLAGS, 4'hf, fflags);
                    st_d  = ST_W_FFLG;
                end
            end
            ST_W_FFLG: begin
                if (acc) begin
                    st_d = ST_DONE;
                end
            end
            ST_DONE: begin
                upd.done    = 1'b1;
                upd.head_we = 1'b1;
                upd.ch      = ch_q;
                upd.head    = next_q;
                upd.comp    = cur_q;
                st_d        = ST_IDLE;
            end
            ST_DROP: begin
                ready = 1'b1;
                if (beat_i.valid && beat_i.last) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Packet state registers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q    <= ST_IDLE;
            mem_q   <= '0;
            cur_q   <= '0;
            first_q <= '0;
            next_q  <= '0;
            buf_q   <= '0;
        end else begin
            st_q    <= st_d;
            mem_q   <= mem_d;
            cur_q   <= cur_d;
            first_q <= first_d;
            next_q  <= next_d;
            buf_q   <= buf_d;
        end
    end

    // Byte counters and packet context.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            size_q <= '0;
            pos_q  <= '0;
            fcnt_q <= '0;
            plen_q <= '0;
            skip_q <= '0;
            ch_q   <= '0;
            byte_q <= '0;
            last_q <= 1'b0;
            isf_q  <= 1'b0;
        end else begin
            size_q <= size_d;
            pos_q  <= pos_d;
            fcnt_q <= fcnt_d;
            plen_q <= plen_d;
            skip_q <= skip_d;
            ch_q   <= ch_d;
            byte_q <= byte_d;
            last_q <= last_d;
            isf_q  <= isf_d;
        end
    end

    // Control register writes; overrun bits clear on ones, a set wins.
    wire       ctrl_wr = reg_i.wr && reg_i.addr == `REG_CTRL;
    wire       mask_wr = reg_i.wr && reg_i.addr == `REG_MASK;
    wire       ovr_wr  = reg_i.wr && reg_i.addr == `REG_OVR;
    wire [7:0] sop_clr = ovr_wr ? reg_i.wdata[7:0] : 8'h00;
    wire [7:0] mop_clr = ovr_wr ? reg_i.wdata[`OVR_MOP_LSB +: 8] : 8'h00;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_q      <= 1'b0;
            mask_q    <= `RST_MASK;
            sop_ovr_q <= 8'h00;
            mop_ovr_q <= 8'h00;
        end else begin
            en_q      <= ctrl_wr ? reg_i.wdata[`CTRL_EN_BIT] : en_q;
            mask_q    <= mask_wr ? reg_i.wdata[7:0] : mask_q;
            sop_ovr_q <= (sop_ovr_q & ~sop_clr) | sop_set;
            mop_ovr_q <= (mop_ovr_q & ~mop_clr) | mop_set;
        end
    end

    // Read selection; data stand only in the cycle after the strobe.
    wire [7:0]  bank  = reg_i.addr & `REG_BANK;
    wire ch_t   rch   = reg_i.addr[4:2];
    wire [31:0] rsel  =
        (bank == `REG_HEAD)       ? head_v[rch] :
        (bank == `REG_COMP)       ? comp_v[rch] :
        (bank == `REG_SKIP)       ? {16'h0000, skip_v[rch]} :
        (reg_i.addr == `REG_CTRL) ? {31'h0, en_q} :
        (reg_i.addr == `REG_MASK) ? {24'h0, mask_q} :
        (reg_i.addr == `REG_PEND) ? {24'h0, pend_v} :
        (reg_i.addr == `REG_OVR)  ? {16'h0, mop_ovr_q, sop_ovr_q} :
        (reg_i.addr == `REG_STAT) ? {25'h0, ch_q, st_q} : 32'h0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= reg_i.rd ? rsel : 32'h0;
        end
    end

    // Outputs; interrupts are masked pending levels.
    assign rdata_o      = rdata_q;
    assign beat_ready_o = ready;
    assign mem_o        = mem_q;
    assign rx_int_o     = pend_v & mask_q;

endmodule // rx_descriptor_queue_dma

//--- rtl/rxdma_defines.svh
// Offsets, field positions, reset values of the receive DMA engine.
// Assumes a byte-addressed register port with 8-bit addresses.
`ifndef RXDMA_DEFINES_SVH
`define RXDMA_DEFINES_SVH

`define NUM_CH       8
`define REG_HEAD     8'h00
`define REG_COMP     8'h20
`define REG_SKIP     8'h40
`define REG_CTRL     8'h60
`define REG_MASK     8'h64
`define REG_PEND     8'h68
`define REG_OVR      8'h6c
`define REG_STAT     8'h70
`define REG_BANK     8'he0
`define CTRL_EN_BIT  0
`define OVR_MOP_LSB  8
`define DESC_NEXT    32'h0000_0000
`define DESC_BUF     32'h0000_0004
`define DESC_LEN     32'h0000_0008
`define DESC_FLAGS   32'h0000_000c
`define FLG_FIRST    31
`define FLG_LAST     30
`define FLG_OWN      29
`define FLG_QEND     28
`define RST_PTR      32'h0000_0000
`define RST_MASK     8'h00

`endif

//--- rtl/rxdma_pkg.sv
// Types shared by the receive DMA engine and its channel table.
// Assumes nothing from the defines header; its widths and state codes are written out here.
package rxdma_pkg;

    typedef logic [2:0]  ch_t;
    typedef logic [31:0] ptr_t;
    typedef logic [15:0] len_t;
    typedef logic [7:0][31:0] ptr_vec_t;
    typedef logic [7:0][15:0] len_vec_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        ch_t        ch;
        logic [7:0] data;
    } beat_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [3:0]  be;
        ptr_t        addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic done;
        logic head_we;
        ch_t  ch;
        ptr_t head;
        ptr_t comp;
    } eng_upd_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0, ST_RD_NEXT = 4'h1, ST_RD_BUF = 4'h3, ST_RD_LEN = 4'h2,
        ST_DATA  = 4'h6, ST_DATA_WR = 4'h7, ST_W_LLEN = 4'h5, ST_W_LFLG = 4'h4,
        ST_W_FLEN = 4'hc, ST_W_FFLG = 4'hd, ST_DONE = 4'hf, ST_DROP = 4'he
    } state_t;

endpackage
